//--- rtl/dba_core.sv
// Device-side burst access logic: command decode, banks, bursts, power states
`timescale 1ns/1ps
`default_nettype none
`include "dba_defs.svh"
// Notes on behaviour
// - Each access moves one 4n word
// - Strobe driven by whoever drives data
// - Read strobe edges align with data
// - Two strobe pairs, one per byte
// - Commands sampled on rising clock only
// - Data on both edges, both directions
// - Every access is a burst from column
// - Activate picks bank and row
// - Read/write picks bank and start column
// - Burst length four or eight only
// - New command interrupts burst of eight
// - Auto precharge closes row after burst
// - Banks work independently of each other
// - Self refresh and power-down states exist
// - Precharge A10 picks one or all
// - A10 requests auto precharge on access
// - Bank inputs select bank or mode register
module dba_core
    import dba_pkg::*;
(
    input wire logic ck,
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    input wire logic [`DBA_DQ_W-1:0] dq_i,
    input wire logic [1:0] dqs_i,
    output logic [`DBA_DQ_W-1:0] dq_rise_o,
    output logic [`DBA_DQ_W-1:0] dq_fall_o,
    output logic dq_oe_n,
    output logic [1:0] dqs_rise_o,
    output logic [1:0] dqs_fall_o,
    output logic [1:0] dqs_oe_n,
    output logic cmd_err,
    output logic wr_ovf,
    output logic dqs_err,
    output logic pdown,
    output logic sref,
    output logic [7:0] ref_ticks
);
    localparam int FW = `DBA_MADDR_W + `DBA_WORD_W;

    function automatic logic [1:0] beat_pos(input logic [1:0] start, input logic [1:0] j,
                                            input logic ilv);
        beat_pos = ilv ? (start ^ j) : (start + j);
    endfunction : beat_pos

    dba_cmd_t cmd;
    dba_pwr_t pwr_r, pwr_nxt;
    logic bl8_r, ilv_r;
    logic rd_act_r, rd_ap_r, rs_v_r, rs_pair_r;
    logic [1:0] rd_pair_r, rd_bank_r, rd_start_r, rs_start_r;
    logic [2:0] rd_colw_r;
    logic wr_act_r, wr_ap_r;
    logic [1:0] wr_pair_r, wr_bank_r, wr_start_r;
    logic [2:0] wr_colw_r;
    logic [`DBA_WORD_W-1:0] wr_acc_r, wr_acc_nxt, mem_q;
    logic [`DBA_DQ_W-1:0] dq_neg_r, dq_rise_r, dq_fall_r;
    logic [1:0] dqs_neg_r, dqs_rise_r, dqs_fall_r, dqs_oe_n_r;
    logic dq_oe_n_r, cmd_err_r, wr_ovf_r, dqs_err_r, pdown_r, sref_r;
    logic sref_m_r, sref_s_r;
    logic [7:0] ref_cnt_r, ref_ticks_r;
    wire [3:0] open_v;
    wire [`DBA_ROW_KEEP-1:0] row_lo [4];

    // Only rising-edge samples reach the decoder; nothing acts in power-down
    wire live = cke && !cs_n && pwr_r == pwr_act;
    wire [2:0] op = {ras_n, cas_n, we_n};
    always_comb begin
        cmd = cmd_nop;
        if (live) begin
            case (op)
                `DBA_OP_LM: cmd = cmd_lm;
                `DBA_OP_REF: cmd = cmd_ref;
                `DBA_OP_PRE: cmd = cmd_pre;
                `DBA_OP_ACT: cmd = cmd_act;
                `DBA_OP_WR: cmd = cmd_wr;
                `DBA_OP_RD: cmd = cmd_rd;
                default: cmd = cmd_nop;
            endcase
        end
    end

    wire bank_open = open_v[ba];
    wire act_go = cmd == cmd_act;
    wire pre_go = cmd == cmd_pre;
    // An access to a closed bank is refused and flagged
    wire rd_go = cmd == cmd_rd && bank_open;
    wire wr_go = cmd == cmd_wr && bank_open;
    wire lm_go = cmd == cmd_lm && ba == `DBA_MR_SEL;
    wire bad_cmd = ((cmd == cmd_rd || cmd == cmd_wr) && !bank_open) || (act_go && bank_open);
    wire [2:0] bl_code = addr[`DBA_MR_BL_MSB:`DBA_MR_BL_LSB];
    wire bl_ok = bl_code == `DBA_BL4 || bl_code == `DBA_BL8;
    wire [1:0] last_pair = bl8_r ? 2'h3 : 2'h1;
    wire rd_end = rd_act_r && rd_pair_r == last_pair;
    wire wr_end = wr_act_r && wr_pair_r == last_pair;
    wire [3:0] ap_close = ({4{rd_end && rd_ap_r}} & (4'h1 << rd_bank_r))
                        | ({4{wr_end && wr_ap_r}} & (4'h1 << wr_bank_r));

    always_ff @(posedge ck or negedge nrst) begin
        if (!nrst) begin
            bl8_r <= 1'b0;
            ilv_r <= 1'b0;
        end else if (lm_go && bl_ok) begin
            bl8_r <= bl_code == `DBA_BL8;
            ilv_r <= addr[`DBA_MR_BT];
        end
    end

    // Each bank keeps its own open flag, so bursts overlap other banks' setup
    for (genvar b = 0; b < 4; b++) begin : g_bank
        logic open_r;
        logic [`DBA_ROW_KEEP-1:0] row_r;
        wire hit = ba == 2'(b);
        always_ff @(posedge ck or negedge nrst) begin
            if (!nrst) begin
                open_r <= 1'b0;
                row_r <= '0;
            end else if (act_go && hit) begin
                open_r <= 1'b1;
                row_r <= addr[`DBA_ROW_KEEP-1:0];
            end else if ((pre_go && (hit || addr[`DBA_A10])) || ap_close[b]) begin
                open_r <= 1'b0;
            end
        end
        assign open_v[b] = open_r;
        assign row_lo[b] = row_r;
    end

    // Read burst: a new read restarts the pair count, cutting the old burst
    always_ff @(posedge ck or negedge nrst) begin
        if (!nrst) begin
            rd_act_r <= 1'b0;
            rd_pair_r <= 2'h0;
            rd_bank_r <= 2'h0;
            rd_colw_r <= 3'h0;
            rd_start_r <= 2'h0;
            rd_ap_r <= 1'b0;
        end else if (rd_go) begin
            rd_act_r <= 1'b1;
            rd_pair_r <= 2'h0;
            rd_bank_r <= ba;
            rd_colw_r <= addr[`DBA_COL_MSB:`DBA_COL_LSB];
            rd_start_r <= addr[`DBA_COL_LSB-1:0];
            rd_ap_r <= addr[`DBA_A10];
        end else if (rd_act_r) begin
            rd_act_r <= !rd_end;
            rd_pair_r <= rd_pair_r + 2'h1;
        end
    end

    // The second half of a burst of eight is the neighbouring 4n word
    wire [`DBA_MADDR_W-1:0] rd_maddr = {rd_bank_r, row_lo[rd_bank_r], rd_colw_r[2:1],
                                        rd_colw_r[0] ^ rd_pair_r[1]};
    wire [`DBA_MADDR_W-1:0] wr_maddr = {wr_bank_r, row_lo[wr_bank_r], wr_colw_r[2:1],
                                        wr_colw_r[0] ^ wr_pair_r[1]};

    always_ff @(posedge ck or negedge nrst) begin
        if (!nrst) begin
            rs_v_r <= 1'b0;
            rs_pair_r <= 1'b0;
            rs_start_r <= 2'h0;
        end else begin
            rs_v_r <= rd_act_r;
            rs_pair_r <= rd_pair_r[0];
            rs_start_r <= rd_start_r;
        end
    end

    wire [1:0] rp0 = beat_pos(rs_start_r, {rs_pair_r, 1'b0}, ilv_r);
    wire [1:0] rp1 = beat_pos(rs_start_r, {rs_pair_r, 1'b1}, ilv_r);
    wire [`DBA_DQ_W-1:0] rd_beat0 = mem_q[{rp0, 4'h0} +: `DBA_DQ_W];
    wire [`DBA_DQ_W-1:0] rd_beat1 = mem_q[{rp1, 4'h0} +: `DBA_DQ_W];

    // Rise/fall registers feed a double-rate output cell at the pins
    always_ff @(posedge ck or negedge nrst) begin
        if (!nrst) begin
            dq_rise_r <= '0;
            dq_fall_r <= '0;
            dq_oe_n_r <= 1'b1;
            dqs_rise_r <= 2'h0;
            dqs_fall_r <= 2'h0;
            dqs_oe_n_r <= 2'h3;
        end else begin
            dq_rise_r <= rd_beat0;
            dq_fall_r <= rd_beat1;
            dq_oe_n_r <= !rs_v_r;
            dqs_rise_r <= {2{rs_v_r}};
            dqs_fall_r <= 2'h0;
            dqs_oe_n_r <= {2{!rs_v_r}};
        end
    end

    // Falling-edge capture of the even write beat and strobe level
    always_ff @(negedge ck or negedge nrst) begin
        if (!nrst) begin
            dq_neg_r <= '0;
            dqs_neg_r <= 2'h0;
        end else begin
            dq_neg_r <= dq_i;
            dqs_neg_r <= dqs_i;
        end
    end

    wire [1:0] wp0 = beat_pos(wr_start_r, {wr_pair_r[0], 1'b0}, ilv_r);
    wire [1:0] wp1 = beat_pos(wr_start_r, {wr_pair_r[0], 1'b1}, ilv_r);
    always_comb begin
        wr_acc_nxt = wr_acc_r;
        wr_acc_nxt[{wp0, 4'h0} +: `DBA_DQ_W] = dq_neg_r;
        wr_acc_nxt[{wp1, 4'h0} +: `DBA_DQ_W] = dq_i;
    end
    // Four beats make one core word, pushed whole
    wire wr_push = wr_act_r && wr_pair_r[0];
    // Each strobe must toggle between the two halves of a write cycle
    wire [1:0] dqs_bad = {2{wr_act_r}} & ~(dqs_neg_r ^ dqs_i);

    always_ff @(posedge ck or negedge nrst) begin
        if (!nrst) begin
            wr_act_r <= 1'b0;
            wr_pair_r <= 2'h0;
            wr_bank_r <= 2'h0;
            wr_colw_r <= 3'h0;
            wr_start_r <= 2'h0;
            wr_ap_r <= 1'b0;
            wr_acc_r <= '0;
        end else begin
            if (wr_act_r) begin
                wr_acc_r <= wr_acc_nxt;
            end
            if (wr_go) begin
                wr_act_r <= 1'b1;
                wr_pair_r <= 2'h0;
                wr_bank_r <= ba;
                wr_colw_r <= addr[`DBA_COL_MSB:`DBA_COL_LSB];
                wr_start_r <= addr[`DBA_COL_LSB-1:0];
                wr_ap_r <= addr[`DBA_A10];
            end else if (wr_act_r) begin
                wr_act_r <= !wr_end;
                wr_pair_r <= wr_pair_r + 2'h1;
            end
        end
    end

    // Reads own the array port; queued writes drain when no read is running.
    // Limitation: a read soon after a write may see the old word.
    wire fifo_rdy, fifo_ov;
    wire [FW-1:0] fifo_od;
    wire mem_we = fifo_ov && !rd_act_r;
    wire [`DBA_MADDR_W-1:0] mem_addr = rd_act_r ? rd_maddr : fifo_od[FW-1:`DBA_WORD_W];

    dba_fifo #(.W(FW), .D(`DBA_FIFO_D)) u_wfifo (
        .clk(ck),
        .nrst(nrst),
        .in_valid(wr_push),
        .in_ready(fifo_rdy),
        .in_data({wr_maddr, wr_acc_nxt}),
        .out_valid(fifo_ov),
        .out_ready(!rd_act_r),
        .out_data(fifo_od)
    );

    dba_mem u_mem (
        .clk(ck),
        .nrst(nrst),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(fifo_od[`DBA_WORD_W-1:0]),
        .rdata(mem_q)
    );

    wire ref_bits = !cs_n && op == `DBA_OP_REF;
    wire idle = !rd_act_r && !wr_act_r && !rs_v_r;
    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            pwr_act: begin
                if (!cke && ref_bits) begin
                    pwr_nxt = pwr_sref;
                end else if (!cke && idle) begin
                    pwr_nxt = pwr_pdn;
                end
            end
            pwr_pdn, pwr_sref: begin
                if (cke) begin
                    pwr_nxt = pwr_act;
                end
            end
            default: pwr_nxt = pwr_act;
        endcase
    end

    always_ff @(posedge ck or negedge nrst) begin
        if (!nrst) begin
            pwr_r <= pwr_act;
            pdown_r <= 1'b0;
            sref_r <= 1'b0;
            cmd_err_r <= 1'b0;
            wr_ovf_r <= 1'b0;
            dqs_err_r <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            pdown_r <= pwr_nxt == pwr_pdn;
            sref_r <= pwr_nxt == pwr_sref;
            cmd_err_r <= bad_cmd;
            wr_ovf_r <= wr_push && !fifo_rdy;
            dqs_err_r <= |dqs_bad;
        end
    end

    // Self refresh runs off the free-running reference clock ref_clk, as the link clock may stop
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sref_m_r <= 1'b0;
            sref_s_r <= 1'b0;
        end else begin
            sref_m_r <= sref_r;
            sref_s_r <= sref_m_r;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ref_cnt_r <= 8'h00;
            ref_ticks_r <= 8'h00;
        end else if (!sref_s_r) begin
            ref_cnt_r <= 8'h00;
        end else if (ref_cnt_r == 8'(`DBA_REF_INT_CYC - 1)) begin
            ref_cnt_r <= 8'h00;
            ref_ticks_r <= ref_ticks_r + 8'h01;
        end else begin
            ref_cnt_r <= ref_cnt_r + 8'h01;
        end
    end

    assign dq_rise_o = dq_rise_r;
    assign dq_fall_o = dq_fall_r;
    assign dq_oe_n = dq_oe_n_r;
    assign dqs_rise_o = dqs_rise_r;
    assign dqs_fall_o = dqs_fall_r;
    assign dqs_oe_n = dqs_oe_n_r;
    assign cmd_err = cmd_err_r;
    assign wr_ovf = wr_ovf_r;
    assign dqs_err = dqs_err_r;
    assign pdown = pdown_r;
    assign sref = sref_r;
    assign ref_ticks = ref_ticks_r;

    default clocking cb @(posedge ck); endclocking
    default disable iff (!nrst);

    sequence s_rd4;
        rd_go && !bl8_r ##1 !rd_go [*2];
    endsequence
    sequence s_wr_pair;
        wr_go ##1 !wr_go;
    endsequence

    rd_burst4_a: assert property (s_rd4 |=> !rd_act_r)
        else $error("burst of four ran too long");
    rd_burst8_a: assert property (rd_go && bl8_r |=> rd_act_r [*4])
        else $error("burst of eight ended early");
    rd_interrupt_a: assert property (rd_go && rd_act_r |=> rd_act_r && rd_pair_r == 2'h0)
        else $error("read interruption not honoured");
    rd_latency_a: assert property (rd_go |-> ##3 !dq_oe_n_r)
        else $error("read data not driven three cycles after command");
    dqs_drive_a: assert property (!dq_oe_n_r |-> dqs_oe_n_r == 2'h0 && dqs_rise_r == 2'h3
                                  && dqs_fall_r == 2'h0)
        else $error("strobe not driven edge aligned with data");
    wr_word_a: assert property (s_wr_pair |=> wr_push)
        else $error("four beats not pushed as one word");
    act_open_a: assert property (act_go |=> open_v[$past(ba)])
        else $error("activate did not open bank");
    bank_iso_a: assert property (act_go && ap_close == 4'h0 |=>
        (open_v | (4'h1 << $past(ba))) == ($past(open_v) | (4'h1 << $past(ba))))
        else $error("activate disturbed another bank");
    rd_addr_a: assert property (rd_go |=> rd_colw_r == $past(addr[4:2])
                                && rd_bank_r == $past(ba))
        else $error("read start column or bank not captured");
    pre_all_a: assert property (pre_go && addr[`DBA_A10] |=> open_v == 4'h0)
        else $error("precharge all left a bank open");
    pre_one_a: assert property (pre_go && !addr[`DBA_A10] |=> !open_v[$past(ba)])
        else $error("precharge left the chosen bank open");
    ap_close_a: assert property (rd_end && rd_ap_r && !act_go |=> !open_v[$past(rd_bank_r)])
        else $error("auto precharge did not close the row");
    mode_sel_a: assert property (cmd == cmd_lm && ba != `DBA_MR_SEL |=> $stable(bl8_r))
        else $error("burst length changed by another mode register");
    cmd_edge_a: assert property (cs_n && ap_close == 4'h0 |=> open_v == $past(open_v))
        else $error("bank state changed on a deselected cycle");
    sref_hold_a: assert property (pwr_r == pwr_sref && !cke |=> pwr_r == pwr_sref)
        else $error("self refresh left without clock enable");
endmodule : dba_core
`default_nettype wire

//--- rtl/dba_defs.svh
// Constants for the burst access logic: widths, field positions, codes, timing
`ifndef DBA_DEFS_SVH
`define DBA_DEFS_SVH
`define DBA_DQ_W 16
`define DBA_WORD_W 64
`define DBA_ROW_KEEP 2
`define DBA_MADDR_W 7
`define DBA_FIFO_D 16
`define DBA_A10 10
`define DBA_COL_LSB 2
`define DBA_COL_MSB 4
`define DBA_MR_SEL 2'h0
`define DBA_MR_BL_LSB 0
`define DBA_MR_BL_MSB 2
`define DBA_MR_BT 3
`define DBA_BL4 3'h2
`define DBA_BL8 3'h3
`define DBA_OP_LM 3'h0
`define DBA_OP_REF 3'h1
`define DBA_OP_PRE 3'h2
`define DBA_OP_ACT 3'h3
`define DBA_OP_WR 3'h4
`define DBA_OP_RD 3'h5
`define DBA_REF_CLK_NS 50
`define DBA_REF_INT_NS 7800
`define DBA_REF_INT_CYC (`DBA_REF_INT_NS / `DBA_REF_CLK_NS)
`endif

//--- rtl/dba_pkg.sv
// Types shared by the burst access logic
`default_nettype none
package dba_pkg;
    typedef enum logic [2:0] {
        cmd_nop, cmd_lm, cmd_ref, cmd_pre, cmd_act, cmd_wr, cmd_rd
    } dba_cmd_t;
    typedef enum logic [1:0] {pwr_act, pwr_pdn, pwr_sref} dba_pwr_t;
endpackage : dba_pkg
`default_nettype wire

//--- rtl/dba_mem.sv
// Single-port array of 4n-bit core words with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "dba_defs.svh"
module dba_mem (
    input wire logic clk,
    input wire logic nrst,
    input wire logic we,
    input wire logic [`DBA_MADDR_W-1:0] addr,
    input wire logic [`DBA_WORD_W-1:0] wdata,
    output logic [`DBA_WORD_W-1:0] rdata
);
    logic [`DBA_WORD_W-1:0] arr_r [1 << `DBA_MADDR_W];

    always_ff @(posedge clk) begin
        if (we) begin
            arr_r[addr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= '0;
        end else begin
            rdata <= arr_r[addr];
        end
    end
endmodule : dba_mem
`default_nettype wire

//--- rtl/dba_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dba_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] buf_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = cnt_r != (AW+1)'(D);
    assign out_valid = cnt_r != '0;
    assign out_data = buf_r[rp_r];

    always_ff @(posedge clk) begin
        if (push) begin
            buf_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : dba_fifo
`default_nettype wire

//--- sim/dba_mc.sv
// Controller model: commands, clock enable, write data and strobes on the link
`timescale 1ns/1ps
`default_nettype none
module dba_mc (
    input wire logic ck,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] ba,
    output logic [12:0] addr,
    output logic [15:0] dq_i,
    output logic [1:0] dqs_i
);
    logic drv = 1'h0;
    initial begin
        {cke, cs_n, ras_n, cas_n, we_n} = 5'h1f;
        ba = 2'h0;
        addr = 13'h0;
        dq_i = 16'h0;
        dqs_i = 2'h0;
    end
    // Released lines change every cycle so a stale capture cannot pass;
    // on the falling edge so they never race a write that starts at the rising one
    always @(negedge ck) begin
        if (!drv) begin
            dq_i <= ~dq_i;
            dqs_i <= ~dqs_i;
        end
    end
    task automatic cmd(input logic [2:0] op, input logic [1:0] b, input logic [12:0] a);
        @(posedge ck);
        {cs_n, ras_n, cas_n, we_n} <= {1'h0, op};
        ba <= b;
        addr <= a;
        @(posedge ck);
        {cs_n, ras_n, cas_n, we_n} <= 4'hf;
    endtask : cmd
    task automatic lp(input logic en, input logic [3:0] c);
        @(posedge ck);
        cke <= en;
        {cs_n, ras_n, cas_n, we_n} <= c;
    endtask : lp
    task automatic wr(input logic [1:0] b, input logic [12:0] a, input int n,
                      input logic [15:0] d[8]);
        cmd(3'h4, b, a);
        drv = 1'h1;
        for (int i = 0; i < n; i += 2) begin
            if (i > 0) @(posedge ck);
            dq_i <= d[i];
            // Strobe edge a quarter cycle later, in the middle of the data eye
            #40 dqs_i <= 2'h0;
            @(negedge ck);
            dq_i <= d[i + 1];
            #40 dqs_i <= 2'h3;
        end
        @(posedge ck);
        drv = 1'h0;
    endtask : wr
    task automatic wr_stuck(input logic [1:0] b, input logic [12:0] a);
        cmd(3'h4, b, a);
        drv = 1'h1;
        // Strobe held still across the first data cycle: the capture must flag it
        dqs_i <= 2'h1;
        @(posedge ck);
        drv = 1'h0;
    endtask : wr_stuck
endmodule : dba_mc
`default_nettype wire

//--- sim/ddr2_burst_access_interface_bench.sv
// Bench for the burst access logic driven by the controller model
`timescale 1ns/1ps
`default_nettype none
module ddr2_burst_access_interface_bench;
    logic ck, ref_clk, nrst, cke, cs_n, ras_n, cas_n, we_n;
    logic dq_oe_n, cmd_err, wr_ovf, dqs_err, pdown, sref;
    logic [1:0] ba, dqs_i, dqs_rise_o, dqs_fall_o, dqs_oe_n;
    logic [12:0] addr;
    logic [15:0] dq_i, dq_rise_o, dq_fall_o;
    logic [7:0] ref_ticks;
    logic [15:0] d[8], e[8], x[8];
    int n_errors = 0;
    int check_count = 0;
    dba_core dba_core_inst (.ck, .ref_clk, .nrst, .cke, .cs_n, .ras_n, .cas_n, .we_n,
        .ba, .addr, .dq_i, .dqs_i, .dq_rise_o, .dq_fall_o, .dq_oe_n, .dqs_rise_o,
        .dqs_fall_o, .dqs_oe_n, .cmd_err, .wr_ovf, .dqs_err, .pdown, .sref, .ref_ticks);
    dba_mc mc (.ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq_i, .dqs_i);
    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        ck = 1'h0;
        #7;
        forever #80 ck = ~ck;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [2:0] pos(input logic [2:0] c, input logic [2:0] i,
                                       input logic il);
        logic [1:0] w;
        w = il ? (c[1:0] ^ i[1:0]) : (c[1:0] + i[1:0]);
        return {c[2] ^ i[2], w};
    endfunction : pos
    task automatic burst(input int n, input logic [15:0] v[16]);
        for (int k = 0; k < n; k++) begin
            #1;
            chk(dq_oe_n, 16'h0);
            chk(dqs_oe_n, 16'h0);
            chk(dqs_rise_o, 16'h3);
            chk(dqs_fall_o, 16'h0);
            chk(dq_rise_o, v[2 * k]);
            chk(dq_fall_o, v[2 * k + 1]);
            @(posedge ck);
        end
        #1;
        chk(dq_oe_n, 16'h1);
        chk(dqs_oe_n, 16'h3);
    endtask : burst
    task automatic rd(input logic [1:0] b, input logic [12:0] a, input int n,
                      input logic il, input logic [15:0] s[8]);
        logic [15:0] v[16];
        for (int i = 0; i < n; i++) v[i] = s[pos(a[2:0], 3'(i), il)];
        mc.cmd(3'h5, b, a);
        // First beat pair stands from the second edge after the command edge
        repeat (2) @(posedge ck);
        burst(n / 2, v);
    endtask : rd
    task automatic rd_err(input logic [1:0] b);
        logic s;
        mc.cmd(3'h5, b, 13'h0);
        #1;
        s = cmd_err;
        @(posedge ck);
        #1 s = s | cmd_err;
        chk(s, 16'h1);
        repeat (2) @(posedge ck);
        #1 chk(dq_oe_n, 16'h1);
    endtask : rd_err
    task automatic t_fill();
        for (int i = 0; i < 8; i++) begin
            d[i] = 16'h1100 + 16'(i);
            e[i] = 16'h2200 + 16'(i);
            x[i] = 16'h3300 + 16'(i);
        end
        #1 chk(dq_oe_n, 16'h1);
        chk(dqs_oe_n, 16'h3);
        chk({cmd_err, pdown, sref}, 16'h0);
        chk(ref_ticks, 16'h0);
        mc.cmd(3'h0, 2'h0, 13'h3);
        mc.cmd(3'h3, 2'h1, 13'h1);
        mc.wr(2'h1, 13'h0, 8, d);
        mc.cmd(3'h3, 2'h2, 13'h1);
        mc.cmd(3'h0, 2'h0, 13'h2);
        mc.wr(2'h2, 13'h0, 4, e);
        // Queued words are only readable once the buffer has drained
        repeat (4) @(posedge ck);
        $display("reset and fill test done");
    endtask : t_fill
    task automatic t_order();
        for (int m = 0; m < 4; m++) begin
            mc.cmd(3'h0, 2'h0, {9'h0, m[0], 2'h1, m[1]});
            rd(2'h1, {10'h0, 3'(2 * m + 1)}, m[1] ? 8 : 4, m[0], d);
        end
        mc.cmd(3'h0, 2'h0, 13'h2);
        mc.cmd(3'h0, 2'h1, 13'h3);
        mc.cmd(3'h0, 2'h0, 13'h5);
        rd(2'h1, 13'h0, 4, 1'h0, d);
        $display("burst order test done");
    endtask : t_order
    task automatic t_intr();
        logic [15:0] v[16];
        for (int i = 0; i < 12; i++) v[i] = (i < 4) ? d[i] : d[pos(3'h4, 3'(i - 4), 1'h0)];
        mc.cmd(3'h0, 2'h0, 13'h3);
        mc.cmd(3'h5, 2'h1, 13'h0);
        mc.cmd(3'h5, 2'h1, 13'h4);
        burst(6, v);
        $display("interrupt test done");
    endtask : t_intr
    task automatic t_banks();
        mc.cmd(3'h0, 2'h0, 13'h2);
        rd(2'h2, 13'h0, 4, 1'h0, e);
        rd(2'h1, 13'h0, 4, 1'h0, d);
        mc.cmd(3'h2, 2'h1, 13'h0);
        rd_err(2'h1);
        rd(2'h2, 13'h0, 4, 1'h0, e);
        mc.cmd(3'h3, 2'h1, 13'h2);
        mc.wr(2'h1, 13'h0, 4, x);
        repeat (4) @(posedge ck);
        rd(2'h1, 13'h0, 4, 1'h0, x);
        mc.cmd(3'h2, 2'h1, 13'h0);
        mc.cmd(3'h3, 2'h1, 13'h1);
        rd(2'h1, 13'h0, 4, 1'h0, d);
        rd(2'h2, 13'h400, 4, 1'h0, e);
        rd_err(2'h2);
        mc.cmd(3'h2, 2'h3, 13'h400);
        rd_err(2'h1);
        $display("bank test done");
    endtask : t_banks
    // Strobe and overflow flags are pulses, so a sticky copy keeps them for later
    logic flag_r = 1'h0;
    always @(posedge ck) begin
        if (dqs_err === 1'b1 || wr_ovf === 1'b1) begin
            flag_r <= 1'h1;
        end
    end
    task automatic t_strobe();
        chk(flag_r, 16'h0);
        mc.cmd(3'h3, 2'h3, 13'h0);
        mc.wr_stuck(2'h3, 13'h0);
        #1 chk(dqs_err, 16'h1);
        @(posedge ck);
        #1 chk(dqs_err, 16'h0);
        $display("strobe test done");
    endtask : t_strobe
    task automatic t_power();
        logic [7:0] t0;
        mc.lp(1'h0, 4'h1);
        mc.lp(1'h0, 4'hf);
        @(posedge ck);
        #1 chk({pdown, sref}, 16'h1);
        t0 = ref_ticks;
        repeat (60) @(posedge ck);
        chk(ref_ticks, t0 + 8'h1);
        mc.lp(1'h1, 4'hf);
        repeat (2) @(posedge ck);
        #1 chk(sref, 16'h0);
        mc.lp(1'h0, 4'hf);
        repeat (2) @(posedge ck);
        #1 chk({pdown, sref}, 16'h2);
        mc.lp(1'h1, 4'hf);
        repeat (2) @(posedge ck);
        #1 chk(pdown, 16'h0);
        $display("power state test done");
    endtask : t_power
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    // Whole sequence needs well under a third of this span
    initial begin
        #300000;
        n_errors++;
        conclude();
    end
    initial begin
        nrst = 1'h0;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'h1;
        t_fill();
        t_order();
        t_intr();
        t_banks();
        t_strobe();
        t_power();
        conclude();
    end
endmodule : ddr2_burst_access_interface_bench
`default_nettype wire
